// ===== src/etm_regs.svh
/*
 * Register offsets, bit positions and reset values of the eight-bit timer
 * channel. Assumes an 8-bit register port addressed by a small word index.
 */
`ifndef ETM_REGS_SVH
`define ETM_REGS_SVH

// ==========================================================
// register indices
`define ETM_ADDR_W 2
`define ETM_OFS_CTRL 2'h0
`define ETM_OFS_CMP 2'h1
`define ETM_OFS_CNT 2'h2
`define ETM_OFS_PORT 2'h3

// ==========================================================
// control register fields
`define ETM_BIT_RUN 7
`define ETM_BIT_MODE 6
`define ETM_BIT_FFSET 3
`define ETM_BIT_FFCLR 2
`define ETM_BIT_INV 1
`define ETM_BIT_OE 0
`define ETM_CTRL_RMASK 8'hC3

// ==========================================================
// port register fields and reset values
`define ETM_BIT_PDIR 1
`define ETM_BIT_PLAT 0
`define ETM_CTRL_RST 8'h00
`define ETM_CMP_RST 8'hFF
`define ETM_PORT_RST 8'h02
`define ETM_CNT_ZERO 8'h00
`define ETM_CNT_ONE 8'h01

`endif

// ===== src/etm_pkg.sv
/*
 * Types of the eight-bit timer channel. Assumes etm_regs.svh for numbers.
 */
package etm_pkg;
  typedef enum logic {ETM_MODE_CLEAR, ETM_MODE_PWM} etm_mode_t;
  typedef logic [7:0] etm_byte_t;
endpackage : etm_pkg

// ===== src/etm_timer.sv
/*
 * Eight-bit interval/PWM timer channel with mode control and pin mux.
 * Assumes a single-master register port on sys_clk, read data one cycle late.
 */
`timescale 1ns/100ps
`default_nettype none
`include "etm_regs.svh"

module etm_timer
  import etm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [`ETM_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic timer_output,
  output logic pin_out,
  output logic pin_oe_n
);

  // ==========================================================
  // reset release
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire logic rst_i_n = rst_s2_q;

  // ==========================================================
  // register decode
  function automatic logic hit(input logic [`ETM_ADDR_W-1:0] a,
                               input logic [`ETM_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire logic wr_ctrl = reg_wr && hit(reg_addr, `ETM_OFS_CTRL);
  wire logic wr_cmp = reg_wr && hit(reg_addr, `ETM_OFS_CMP);
  wire logic wr_port = reg_wr && hit(reg_addr, `ETM_OFS_PORT);

  logic [7:0] ctrl_q;
  logic [7:0] cmp_q;
  logic [7:0] port_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic ff_q;
  logic ff_d;
  logic pwm_q;
  logic pwm_d;
  logic [7:0] rdata_q;

  wire logic run = ctrl_q[`ETM_BIT_RUN];
  wire etm_mode_t mode = etm_mode_t'(ctrl_q[`ETM_BIT_MODE]);
  wire logic inv = ctrl_q[`ETM_BIT_INV];
  wire logic oe = ctrl_q[`ETM_BIT_OE];
  wire logic is_pwm = (mode == ETM_MODE_PWM);
  wire logic match = run && (cnt_q == cmp_q);
  wire logic wr_set = wr_ctrl && reg_wdata[`ETM_BIT_FFSET];
  wire logic wr_clr = wr_ctrl && reg_wdata[`ETM_BIT_FFCLR];
  wire logic wr_pwm = reg_wdata[`ETM_BIT_MODE];

  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      ctrl_q <= `ETM_CTRL_RST;
      cmp_q <= `ETM_CMP_RST;
      port_q <= `ETM_PORT_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= reg_wdata & `ETM_CTRL_RMASK;
      if (wr_cmp) cmp_q <= reg_wdata;
      if (wr_port) port_q <= reg_wdata;
    end
  end

  // ==========================================================
  // counter
  // run bit clears and starts
  // clear on match or wrap in PWM
  always_comb begin
    cnt_d = cnt_q;
    if (!run) begin
      cnt_d = `ETM_CNT_ZERO;
    end else if (!is_pwm && match) begin
      cnt_d = `ETM_CNT_ZERO;
    end else begin
      cnt_d = cnt_q + `ETM_CNT_ONE;
    end
  end

  // ==========================================================
  // output flip-flop and pwm level
  // preset by a write that does not select PWM, toggle on match outside PWM when inv is set
  always_comb begin
    ff_d = ff_q;
    if (wr_ctrl && !wr_pwm && wr_clr && !wr_set) begin
      ff_d = 1'b0;
    end else if (wr_ctrl && !wr_pwm && wr_set && !wr_clr) begin
      ff_d = 1'b1;
    end else if (!is_pwm && inv && match) begin
      ff_d = ~ff_q;
    end
  end

  // active while count below compare; inactive whenever stopped
  always_comb begin
    pwm_d = pwm_q;
    if (!run) begin
      pwm_d = 1'b0;
    end else if (cnt_q == `ETM_CNT_ZERO) begin
      pwm_d = (cmp_q != `ETM_CNT_ZERO);
    end else if (match) begin
      pwm_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      cnt_q <= `ETM_CNT_ZERO;
      ff_q <= 1'b0;
      pwm_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ff_q <= ff_d;
      pwm_q <= pwm_d;
    end
  end

  // ==========================================================
  // timer output and pin
  // stopped pwm inactive, level select, bits act directly
  // gated by run so a stop reaches the pin at once, not one edge late
  wire logic pwm_lvl = (run && pwm_q) ^ inv;
  wire logic raw_out = is_pwm ? pwm_lvl : ff_q;
  assign timer_output = oe & raw_out;
  // pin = timer output xor latch, driven when direction is output
  assign pin_out = timer_output ^ port_q[`ETM_BIT_PLAT];
  assign pin_oe_n = port_q[`ETM_BIT_PDIR];

  // ==========================================================
  // read port
  wire logic [7:0] rsel = hit(reg_addr, `ETM_OFS_CTRL) ? ctrl_q :
                          hit(reg_addr, `ETM_OFS_CMP) ? cmp_q :
                          hit(reg_addr, `ETM_OFS_CNT) ? cnt_q : port_q;
  always_ff @(posedge sys_clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      rdata_q <= `ETM_CNT_ZERO;
    end else begin
      rdata_q <= reg_rd ? rsel : `ETM_CNT_ZERO;
    end
  end
  assign reg_rdata = rdata_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_i_n);

  chk_stop_clears: assert property (!run |=> cnt_q == `ETM_CNT_ZERO)
    else $error("counter not cleared while stopped");
  chk_count_up: assert property (run && !match && $past(run) |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("counter did not advance");
  chk_match_clear: assert property (run && !is_pwm && match && $stable(ctrl_q) |=> cnt_q == 8'h00)
    else $error("no clear on compare match");
  chk_preset_set: assert property (wr_ctrl && !wr_pwm && wr_set && !wr_clr |=> ff_q)
    else $error("preset set failed");
  chk_preset_clr: assert property (wr_ctrl && !wr_pwm && wr_clr && !wr_set |=> !ff_q)
    else $error("preset clear failed");
  chk_toggle_off: assert property (!is_pwm && !inv && !wr_ctrl |=> $stable(ff_q))
    else $error("flip-flop toggled while disabled");
  chk_ro_preset: assert property (reg_rd && hit(reg_addr, `ETM_OFS_CTRL) |=> reg_rdata[3:2] == 2'h0)
    else $error("preset bits read nonzero");
  chk_pwm_stop: assert property (is_pwm && !run && oe && $past(!run) |-> timer_output == inv)
    else $error("stopped pwm not inactive");
  chk_oe_low: assert property (!oe |-> !timer_output)
    else $error("output high while disabled");
  chk_pwm_preset: assert property (wr_ctrl && wr_pwm && !is_pwm && !match |=> $stable(ff_q))
    else $error("preset acted in pwm mode");
  chk_pin_mux: assert property (pin_out == (timer_output ^ port_q[0]))
    else $error("pin level mismatch");

  cov_match: cover property (run && !is_pwm && match);
  cov_pwm_cycle: cover property (is_pwm && pwm_q ##1 !pwm_q);
  cov_toggle: cover property (!is_pwm && inv && match ##1 run);
endmodule : etm_timer
`default_nettype wire

// ===== dv/etm_tb.sv
/* Self-checking bench for the eight-bit timer channel.
   Assumes etm_pkg, etm_regs.svh and etm_timer are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "etm_regs.svh"
module testbench;
  import etm_pkg::*;
  logic sys_clk, rst_n, reg_wr, reg_rd, timer_output, pin_out, pin_oe_n, prev;
  logic [`ETM_ADDR_W-1:0] reg_addr;
  etm_byte_t reg_wdata, reg_rdata, rd_v, c;
  int failures = 0, compares = 0, seed = 32'h79d1, cmp, hits, togs, i;
  etm_timer dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_output(timer_output), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ========
  // bus tasks and compare
  task automatic check(input string what, input etm_byte_t exp, input etm_byte_t got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [1:0] a, input etm_byte_t d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(negedge sys_clk);
  endtask : wr
  task automatic rd(input logic [1:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    rd_v = reg_rdata;
  endtask : rd
  task automatic out(input string what, input logic e);
    check(what, {7'h00, e}, {7'h00, timer_output});
  endtask : out
  // window a whole number of periods, so counts are exact
  task automatic watch(input int n);
    hits = 0;
    togs = 0;
    prev = timer_output;
    repeat (n) begin
      @(negedge sys_clk);
      if (timer_output === 1'b1) hits++;
      if (timer_output !== prev) togs++;
      prev = timer_output;
    end
  endtask : watch
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  initial begin
    #4000000;
    failures++;
    end_sim();
  end
  // ========
  // main sequence
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, rst_n} = '0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(`ETM_OFS_CTRL); check("ctrl reset", `ETM_CTRL_RST, rd_v);
    rd(`ETM_OFS_CMP); check("cmp reset", `ETM_CMP_RST, rd_v);
    rd(`ETM_OFS_PORT); check("port reset", `ETM_PORT_RST, rd_v);
    $display("test reset done");
    wr(`ETM_OFS_CTRL, 8'h08); out("oe off", 1'b0);
    rd(`ETM_OFS_CTRL); check("preset readback", 8'h00, rd_v);
    wr(`ETM_OFS_CTRL, 8'h09); out("ff set", 1'b1);
    rd(`ETM_OFS_CTRL); check("preset readback", 8'h01, rd_v);
    wr(`ETM_OFS_CTRL, 8'h01); out("ff keep", 1'b1);
    wr(`ETM_OFS_CTRL, 8'h05); out("ff clear", 1'b0);
    wr(`ETM_OFS_CTRL, 8'h0D); out("ff both", 1'b0);
    for (i = 0; i < 4; i++) begin
      wr(`ETM_OFS_PORT, 8'(i));
      check("pin_out", 8'(i & 1), {7'h00, pin_out});
      check("pin_oe_n", 8'(i >> 1), {7'h00, pin_oe_n});
    end
    wr(`ETM_OFS_PORT, 8'h00);
    $display("test presets done");
    cmp = 2 + ($random(seed) & 8'h1F);
    // mode and level first, run last, stop alone
    wr(`ETM_OFS_CMP, 8'(cmp));
    wr(`ETM_OFS_CTRL, 8'h03);
    wr(`ETM_OFS_CTRL, 8'h83);
    watch(10 * (cmp + 1)); check("toggles", 8'd10, 8'(togs));
    repeat (4) begin
      rd(`ETM_OFS_CNT); check("count bound", 8'h01, {7'h00, rd_v <= 8'(cmp)});
    end
    wr(`ETM_OFS_CTRL, 8'h03);
    rd(`ETM_OFS_CNT); check("stopped count", 8'h00, rd_v);
    watch(3 * (cmp + 1)); check("stopped toggles", 8'd0, 8'(togs));
    wr(`ETM_OFS_CTRL, 8'h01);
    wr(`ETM_OFS_CTRL, 8'h81);
    watch(4 * (cmp + 1)); check("no toggle", 8'd0, 8'(togs));
    wr(`ETM_OFS_CTRL, 8'h01);
    $display("test clear mode done");
    cmp = 1 + ($random(seed) & 8'h7F);
    wr(`ETM_OFS_CMP, 8'(cmp));
    for (i = 0; i < 2; i++) begin
      c = 8'h41 | 8'(i << 1);
      wr(`ETM_OFS_CTRL, c); out("pwm idle", i[0]);
      wr(`ETM_OFS_CTRL, c | 8'h08); out("pwm preset", i[0]);
      wr(`ETM_OFS_CTRL, c | 8'h04); out("pwm preset", i[0]);
      wr(`ETM_OFS_CTRL, c | 8'h80);
      watch(256); check("duty", 8'(i ? 256 - cmp : cmp), 8'(hits));
      wr(`ETM_OFS_CTRL, c); out("pwm stop", i[0]);
    end
    $display("test pwm done");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
